// >>> pvs_port.v
// Serial PCM voice port with APB registers, master or slave framing.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pvs_consts.vh"
module pvs_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        pcm_bclk_in,
  output reg         pcm_bclk_out,
  output reg         pcm_bclk_oe_n,
  input  wire        pcm_sync_in,
  output reg         pcm_sync_out,
  output reg         pcm_sync_oe_n,
  input  wire        pcm_din,
  output reg         pcm_dout,
  output reg         pcm_dout_oe_n
);
  reg  [13:0] ctrl;
  reg  [7:0]  clkdiv;
  reg  [7:0]  frlen;
  reg  [2:0]  fill_val;
  reg  [15:0] tx_data;
  reg  [15:0] rx_data;
  reg         rx_valid;
  reg         tx_loaded;
  reg         rate_err;
  reg  [7:0]  frame_cnt;
  reg         locked;
  reg  [7:0]  div_cnt;
  reg  [7:0]  bitcnt;
  reg         start_pend;
  reg  [7:0]  start_val;
  reg         bclk_d;
  reg         fs_prev;
  reg  [15:0] tx_sh;
  reg  [15:0] rx_sh;
  reg  [7:0]  per_cnt;
  reg  [31:0] rd_mux;
  reg         addr_ok;
  reg  [7:0]  next_bit;
  wire [2:0]  pins_s;
  wire [15:0] tx_word;
  wire [15:0] rx_sample;
  wire        bclk_s;
  wire        fs_s;
  wire        din_s;

  wire       en        = ctrl[`PVS_CTRL_EN];
  wire       master    = ctrl[`PVS_CTRL_MASTER];
  wire       long_sync = ctrl[`PVS_CTRL_LONG];
  // Burst needs the host to set the command bit; nothing else raises the rate.
  wire       burst     = ctrl[`PVS_CTRL_BURST];
  wire [3:0] own_slot  = ctrl[`PVS_CTRL_SLOT];

  // The programmed divider is clamped so the bit clock stays in its limit.
  wire [31:0] half_min_w = burst ? `PVS_HALF_MIN_BURST : `PVS_HALF_MIN;
  wire [7:0]  half_min   = half_min_w[7:0];
  wire [7:0] half     = (clkdiv < half_min) ? half_min : clkdiv;

  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable & pready;
  wire wr_acc    = apb_acc & pwrite & ~pslverr;
  wire rd_acc    = apb_acc & ~pwrite & ~pslverr;

  pvs_sync2 #(
    .W (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({pcm_bclk_in, pcm_sync_in, pcm_din}),
    .q       (pins_s)
  );

  assign bclk_s = pins_s[2];
  assign fs_s   = pins_s[1];
  assign din_s  = pins_s[0];

  pvs_fmt u_fmt (
    .mode      (ctrl[`PVS_CTRL_MODE]),
    .fill_sel  (ctrl[`PVS_CTRL_FILL]),
    .fill_val  (fill_val),
    .rjust     (ctrl[`PVS_CTRL_RJUST]),
    .lsb_first (ctrl[`PVS_CTRL_LSBF]),
    .tx_sample (tx_data),
    .rx_word   (rx_sh),
    .tx_word   (tx_word),
    .rx_sample (rx_sample)
  );

  // Bit clock events: from the own divider as master, from the synced pin as slave.
  wire div_tick = master & en & (div_cnt == 8'h00);
  wire rise_ev  = master ? (div_tick & ~pcm_bclk_out) : (en & bclk_s & ~bclk_d);
  wire fall_ev  = master ? (div_tick & pcm_bclk_out) : (en & ~bclk_s & bclk_d);
  wire active   = en & (master | locked);
  wire own_now  = (bitcnt[7:4] == own_slot);
  wire own_next = (next_bit[7:4] == own_slot);

  always @* begin
    if (!master && start_pend) begin
      next_bit = start_val;
    end else if (bitcnt >= frlen) begin
      next_bit = 8'h00;
    end else begin
      next_bit = bitcnt + 8'h01;
    end
  end

  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    case (paddr)
      `PVS_ADDR_CTRL:   rd_mux = {18'h00000, ctrl};
      `PVS_ADDR_CLKDIV: rd_mux = {24'h000000, clkdiv};
      `PVS_ADDR_FRLEN:  rd_mux = {24'h000000, frlen};
      `PVS_ADDR_FILL:   rd_mux = {29'h00000000, fill_val};
      `PVS_ADDR_TXDATA: rd_mux = {16'h0000, tx_data};
      `PVS_ADDR_RXDATA: rd_mux = {16'h0000, rx_data};
      `PVS_ADDR_STATUS: rd_mux = {16'h0000, frame_cnt, 3'h0, locked, burst, rate_err, tx_loaded, rx_valid};
      default:          addr_ok = 1'b0;
    endcase
  end

  // APB answers in the first access cycle; prdata is latched at setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      if (apb_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `PVS_RST_CTRL;
      clkdiv   <= `PVS_RST_CLKDIV;
      frlen    <= `PVS_RST_FRLEN;
      fill_val <= `PVS_RST_FILL;
      tx_data  <= 16'h0000;
    end else if (wr_acc) begin
      case (paddr)
        `PVS_ADDR_CTRL:   ctrl     <= pwdata[`PVS_CTRL_W-1:0];
        `PVS_ADDR_CLKDIV: clkdiv   <= pwdata[7:0];
        `PVS_ADDR_FRLEN:  frlen    <= pwdata[7:0];
        `PVS_ADDR_FILL:   fill_val <= pwdata[2:0];
        `PVS_ADDR_TXDATA: tx_data  <= pwdata[15:0];
        default:          tx_data  <= tx_data;
      endcase
    end
  end

  // Master bit clock divider; it idles low while disabled or in slave role.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt      <= 8'h00;
      pcm_bclk_out <= 1'b0;
    end else if (!(master && en)) begin
      div_cnt      <= 8'h00;
      pcm_bclk_out <= 1'b0;
    end else if (div_tick) begin
      div_cnt      <= half - 8'h01;
      pcm_bclk_out <= ~pcm_bclk_out;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_bclk_oe_n <= 1'b1;
      pcm_sync_oe_n <= 1'b1;
      bclk_d        <= 1'b0;
    end else begin
      pcm_bclk_oe_n <= ~(master & en);
      pcm_sync_oe_n <= ~(master & en);
      bclk_d        <= bclk_s;
    end
  end

  // Framing: bit counter, master sync pulse, slave sync detection.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt       <= 8'h00;
      start_pend   <= 1'b0;
      start_val    <= 8'h00;
      fs_prev      <= 1'b0;
      locked       <= 1'b0;
      pcm_sync_out <= 1'b0;
      frame_cnt    <= 8'h00;
    end else if (!en) begin
      // Parked on the last bit so the first rising edge opens bit 0 and a long sync is full width.
      bitcnt       <= frlen;
      start_pend   <= 1'b0;
      locked       <= 1'b0;
      pcm_sync_out <= 1'b0;
    end else begin
      if (rise_ev) begin
        bitcnt     <= next_bit;
        start_pend <= 1'b0;
        if (master) begin
          // Short: high through the last bit so the slave sees it on the falling edge.
          // Long: high for the first three bits of the frame.
          if (long_sync) begin
            pcm_sync_out <= (next_bit < `PVS_LONG_BITS);
          end else begin
            pcm_sync_out <= (next_bit == frlen);
          end
          if (next_bit == 8'h00) begin
            frame_cnt <= frame_cnt + 8'h01;
          end
        end
      end
      if (fall_ev && !master) begin
        fs_prev <= fs_s;
        if (long_sync ? (fs_s && !fs_prev) : fs_s) begin
          // Long sync is seen inside bit 0, so the next rising edge opens bit 1.
          start_pend <= 1'b1;
          start_val  <= long_sync ? 8'h01 : 8'h00;
          locked     <= 1'b1;
          frame_cnt  <= frame_cnt + 8'h01;
        end
      end
    end
  end

  // Transmit shifter and output enable for the owned slot only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh         <= 16'h0000;
      pcm_dout      <= 1'b0;
      pcm_dout_oe_n <= 1'b1;
    end else if (!active) begin
      pcm_dout_oe_n <= 1'b1;
    end else if (rise_ev) begin
      if (!own_next) begin
        pcm_dout_oe_n <= 1'b1;
      end else if (next_bit[3:0] == 4'h0) begin
        tx_sh         <= {tx_word[14:0], 1'b0};
        pcm_dout      <= tx_word[15];
        pcm_dout_oe_n <= 1'b0;
      end else begin
        tx_sh    <= {tx_sh[14:0], 1'b0};
        pcm_dout <= tx_sh[15];
      end
    end else if (fall_ev && own_now && bitcnt[3:0] == `PVS_SLOT_LAST) begin
      // Released mid last bit: the far end has already sampled it on the falling edge.
      pcm_dout_oe_n <= 1'b1;
    end
  end

  // Receive shifter; spare bits are dropped by the formatter.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh <= 16'h0000;
    end else if (active && fall_ev && own_now) begin
      rx_sh <= {rx_sh[14:0], din_s};
    end
  end

  wire rx_done = active && fall_ev && own_now && (bitcnt[3:0] == `PVS_SLOT_LAST);
  reg  rx_done_d;
  wire tx_load = active && rise_ev && own_next && (next_bit[3:0] == 4'h0);

  // Status flags: a new event wins over a clear in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done_d <= 1'b0;
      rx_data   <= 16'h0000;
      rx_valid  <= 1'b0;
      tx_loaded <= 1'b0;
    end else begin
      rx_done_d <= rx_done;
      if (rx_done_d) begin
        rx_data  <= rx_sample;
        rx_valid <= 1'b1;
      end else if (rd_acc && paddr == `PVS_ADDR_RXDATA) begin
        rx_valid <= 1'b0;
      end
      if (tx_load) begin
        tx_loaded <= 1'b1;
      end else if (wr_acc && paddr == `PVS_ADDR_TXDATA) begin
        tx_loaded <= 1'b0;
      end
    end
  end

  // Slave rate guard: flags bit clocks faster than the allowed rate.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt  <= 8'h00;
      rate_err <= 1'b0;
    end else begin
      if (master || !en) begin
        per_cnt <= 8'h00;
      end else if (rise_ev) begin
        per_cnt <= 8'h00;
      end else if (per_cnt != 8'hFF) begin
        per_cnt <= per_cnt + 8'h01;
      end
      if (!master && rise_ev && locked && (per_cnt < {half_min[6:0], 1'b0} - 8'h01)) begin
        rate_err <= 1'b1;
      end else if (wr_acc && paddr == `PVS_ADDR_STATUS && pwdata[`PVS_ST_RATE]) begin
        rate_err <= 1'b0;
      end
    end
  end
endmodule

// >>> pvs_consts.vh
// Constants and register map of the serial PCM voice port.
`ifndef PVS_CONSTS_VH
`define PVS_CONSTS_VH

`define PVS_PCLK_MHZ       125
`define PVS_BCLK_MAX_MHZ   12
`define PVS_BURST_MAX_MHZ  24
`define PVS_BIT_MIN_CYC    ((`PVS_PCLK_MHZ + `PVS_BCLK_MAX_MHZ - 1) / `PVS_BCLK_MAX_MHZ)
`define PVS_BURST_MIN_CYC  ((`PVS_PCLK_MHZ + `PVS_BURST_MAX_MHZ - 1) / `PVS_BURST_MAX_MHZ)
`define PVS_HALF_MIN       ((`PVS_BIT_MIN_CYC + 1) / 2)
`define PVS_HALF_MIN_BURST ((`PVS_BURST_MIN_CYC + 1) / 2)

`define PVS_ADDR_CTRL   8'h00
`define PVS_ADDR_CLKDIV 8'h04
`define PVS_ADDR_FRLEN  8'h08
`define PVS_ADDR_FILL   8'h0C
`define PVS_ADDR_TXDATA 8'h10
`define PVS_ADDR_RXDATA 8'h14
`define PVS_ADDR_STATUS 8'h18

`define PVS_CTRL_EN     0
`define PVS_CTRL_MASTER 1
`define PVS_CTRL_LONG   2
`define PVS_CTRL_MODE   4:3
`define PVS_CTRL_BURST  5
`define PVS_CTRL_FILL   7:6
`define PVS_CTRL_RJUST  8
`define PVS_CTRL_LSBF   9
`define PVS_CTRL_SLOT   13:10
`define PVS_CTRL_W      14

`define PVS_MODE_NB   2'h0
`define PVS_MODE_WBV  2'h1
`define PVS_MODE_SBC  2'h2

`define PVS_FILL_ZERO 2'h0
`define PVS_FILL_ONES 2'h1
`define PVS_FILL_SIGN 2'h2
`define PVS_FILL_PROG 2'h3

`define PVS_RST_CTRL   14'h0000
`define PVS_RST_CLKDIV 8'h06
`define PVS_RST_FRLEN  8'h0F
`define PVS_RST_FILL   3'h0

`define PVS_ST_RXV    0
`define PVS_ST_TXL    1
`define PVS_ST_RATE   2
`define PVS_ST_BURST  3
`define PVS_ST_LOCK   4
`define PVS_ST_FCNT   15:8

`define PVS_LONG_BITS 8'h03
`define PVS_SLOT_LAST 4'hF

`endif

// >>> pvs_sync2.v
// Two-flop synchroniser for pins that come from outside the pclk domain.
`timescale 1ns/1ps
module pvs_sync2 #(
  parameter W = 3
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> pvs_fmt.v
// Slot word formatting: 13-bit narrowband packing, filler and bit order.
`timescale 1ns/1ps
`include "pvs_consts.vh"
module pvs_fmt (
  input  wire [1:0]  mode,
  input  wire [1:0]  fill_sel,
  input  wire [2:0]  fill_val,
  input  wire        rjust,
  input  wire        lsb_first,
  input  wire [15:0] tx_sample,
  input  wire [15:0] rx_word,
  output reg  [15:0] tx_word,
  output reg  [15:0] rx_sample
);
  reg [2:0]  fill;
  reg [15:0] slot_word;
  reg [15:0] rx_ord;

  function [15:0] rev16;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1)
        rev16[i] = v[15-i];
    end
  endfunction

  always @* begin
    case (fill_sel)
      `PVS_FILL_ZERO: fill = 3'h0;
      `PVS_FILL_ONES: fill = 3'h7;
      `PVS_FILL_SIGN: fill = {3{tx_sample[12]}};
      default:        fill = fill_val;
    endcase
    // Wideband and SBC words pass whole; only narrowband is packed.
    if (mode == `PVS_MODE_NB) begin
      slot_word = rjust ? {fill, tx_sample[12:0]} : {tx_sample[12:0], fill};
    end else begin
      slot_word = tx_sample;
    end
    tx_word = lsb_first ? rev16(slot_word) : slot_word;
    rx_ord  = lsb_first ? rev16(rx_word) : rx_word;
    // Narrowband spare bits are dropped and the sample is sign extended; other modes pass whole.
    if (mode == `PVS_MODE_NB) begin
      rx_sample = rjust ? {{3{rx_ord[12]}}, rx_ord[12:0]} : {{3{rx_ord[15]}}, rx_ord[15:3]};
    end else begin
      rx_sample = rx_ord;
    end
  end
endmodule

// >>> pvs_port_monitor.sv
// Pin-level checker for the voice port.
`timescale 1ns/1ps
module pvs_port_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic pcm_bclk_out,
  input logic pcm_bclk_oe_n,
  input logic pcm_sync_out,
  input logic pcm_sync_oe_n,
  input logic pcm_dout,
  input logic pcm_dout_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       bq;
  logic [4:0] syn;
  logic [4:0] oen;
  wire        brise = pcm_bclk_out && !bq;
  // Rises are counted so that width checks hold whether an output moves on the rise or one pclk later.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bq <= 1'h0;
      syn <= 5'h00;
      oen <= 5'h00;
    end else begin
      bq <= pcm_bclk_out;
      syn <= pcm_sync_out ? syn + {4'h0, brise} : 5'h00;
      oen <= pcm_dout_oe_n ? 5'h00 : oen + {4'h0, brise};
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pulse_s;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (setup_s |=> pulse_s)
    else $error("pready not one cycle after setup");
  slverr_pair_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  master_pins_a: assert property (pcm_bclk_oe_n == pcm_sync_oe_n)
    else $error("clock and sync drive differ");
  bclk_rate_a: assert property ($changed(pcm_bclk_out) && !pcm_bclk_oe_n |=> ($stable(pcm_bclk_out) || pcm_bclk_oe_n) [*2])
    else $error("bit clock too fast");
  sync_edge_a: assert property ($changed(pcm_sync_out) && !pcm_sync_oe_n |-> pcm_bclk_out)
    else $error("sync moved off rising edge");
  sync_width_a: assert property ($fell(pcm_sync_out) && !pcm_sync_oe_n |-> syn == 5'h01 || syn == 5'h03)
    else $error("sync width wrong");
  dout_launch_a: assert property ($changed(pcm_dout) && !pcm_dout_oe_n && !pcm_bclk_oe_n |-> pcm_bclk_out)
    else $error("data moved off rising edge");
  dout_release_a: assert property ($rose(pcm_dout_oe_n) && !pcm_bclk_oe_n |-> !pcm_bclk_out)
    else $error("release not in low half of last bit");
  slot_span_a: assert property ($rose(pcm_dout_oe_n) && !pcm_bclk_oe_n |-> oen == 5'h0F || oen == 5'h10)
    else $error("driven span is not one slot");
  reset_idle_a: assert property ($rose(presetn) |-> pcm_dout_oe_n && pcm_bclk_oe_n && pcm_sync_oe_n)
    else $error("pins driven after reset");
endmodule

// >>> pvs_codec_model.sv
// Codec partner: bit clock master when the port is slave, follower otherwise.
`timescale 1ns/1ps
module pvs_codec_model (
  input  logic        bclk,
  input  logic        sync,
  input  logic        dout,
  input  logic        long_sync,
  input  logic [15:0] tx_word,
  output logic        bclk_drv,
  output logic        sync_drv,
  output logic        din,
  output logic [15:0] rx_word,
  output int          frames
);
  logic [3:0]  bitc;
  logic [15:0] sh;
  logic        sq;
  initial begin
    bclk_drv = 1'h0;
    sync_drv = 1'h0;
    din = 1'h0;
    rx_word = 16'h0000;
    frames = 0;
    bitc = 4'h0;
    sh = 16'h0000;
    sq = 1'h0;
  end
  // The clock stands still between bursts; a short-sync preamble bit opens the first frame.
  task automatic run(input int n);
    for (int b = -1; b < 16 * n; b++) begin
      bclk_drv = 1'h1;
      sync_drv = long_sync ? (b >= 0 && b % 16 < 3) : (b < 0 || b % 16 == 15);
      #62.5;
      bclk_drv = 1'h0;
      #62.5;
    end
    sync_drv = 1'h0;
  endtask
  always @(bclk) begin
    if (bclk) begin
      bitc <= bitc + 4'h1;
      din <= tx_word[4'hE - bitc];
    end else begin
      sq <= sync;
      sh <= {sh[14:0], dout};
      if (bitc == 4'hF) begin
        rx_word <= {sh[14:0], dout};
        frames <= frames + 1;
      end
      if (long_sync ? (sync && !sq) : sync)
        bitc <= long_sync ? 4'h0 : 4'hF;
    end
  end
endmodule

// >>> pvs_port_tb.sv
// Self-checking bench for the voice port with its codec partner.
`timescale 1ns/1ps
`include "pvs_consts.vh"
module pvs_port_tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seed = 32'hE0B7947F;
  logic        pready, pslverr, er, bclk_out, bclk_oe_n, sync_out, sync_oe_n, dout, dout_oe_n;
  logic        din, dpin, m_bclk, m_sync, long_sync = 1'h0;
  logic [15:0] m_tx = 16'h0000, m_rx;
  int          frames, errors = 0, compares = 0, cyc = 0;
  wire         bclk_pin = bclk_oe_n ? m_bclk : bclk_out;
  wire         sync_pin = sync_oe_n ? m_sync : sync_out;
  // A released data line shows the inverse of its last level; the delay gives the codec its setup view.
  assign #1 dpin = dout ^ dout_oe_n;
  pvs_port dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcm_bclk_in(bclk_pin),
    .pcm_bclk_out(bclk_out), .pcm_bclk_oe_n(bclk_oe_n), .pcm_sync_in(sync_pin), .pcm_sync_out(sync_out),
    .pcm_sync_oe_n(sync_oe_n), .pcm_din(din), .pcm_dout(dout), .pcm_dout_oe_n(dout_oe_n)
  );
  pvs_codec_model codec_u (
    .bclk(bclk_pin), .sync(sync_pin), .dout(dpin), .long_sync(long_sync), .tx_word(m_tx),
    .bclk_drv(m_bclk), .sync_drv(m_sync), .din(din), .rx_word(m_rx), .frames(frames)
  );
  always #4 pclk = ~pclk;
  task give_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: register got %h exp %h", $time, g, e);
    end
  endtask
  task chk_wd(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: slot word got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] rev(input logic [15:0] w);
    for (int k = 0; k < 16; k++)
      rev[k] = w[15 - k];
  endfunction
  function automatic logic [15:0] tx_exp(input logic [13:0] c, input logic [2:0] fv, input logic [15:0] s);
    logic [2:0]  f;
    logic [15:0] w;
    f = c[7:6] == 2'h0 ? 3'h0 : c[7:6] == 2'h1 ? 3'h7 : c[7:6] == 2'h2 ? {3{s[12]}} : fv;
    w = c[4:3] != 2'h0 ? s : c[8] ? {f, s[12:0]} : {s[12:0], f};
    return c[9] ? rev(w) : w;
  endfunction
  function automatic logic [15:0] rx_exp(input logic [13:0] c, input logic [15:0] w);
    logic [15:0] u;
    logic [12:0] v;
    u = c[9] ? rev(w) : w;
    v = c[8] ? u[12:0] : u[15:3];
    return c[4:3] != 2'h0 ? u : {{3{v[12]}}, v};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic frame_test(input int i);
    logic [13:0] c;
    logic [31:0] r, div;
    logic [15:0] s;
    logic        b;
    int          n, g, h, f0;
    c = {4'h0, i == 3, i[2], i[1:0], i == 5, i == 6 ? 2'h1 : i == 7 ? 2'h2 : 2'h0, i[1], i[0], 1'h1};
    r = rnd();
    s = c[4:3] != 2'h0 ? r[31:16] : {3'h0, r[28:16]};
    div = {29'h0, r[6:4]} + 32'h1;
    m_tx = r[15:0] ^ rnd();
    long_sync = i[1];
    apb(1'h1, `PVS_ADDR_FILL, {29'h0, r[9:7]});
    apb(1'h1, `PVS_ADDR_CLKDIV, div);
    apb(1'h1, `PVS_ADDR_TXDATA, {16'h0, s});
    apb(1'h1, `PVS_ADDR_CTRL, {18'h0, c});
    apb(1'h0, `PVS_ADDR_STATUS, 32'h0);
    chk_reg({31'h0, rd[3]}, {31'h0, c[5]});
    if (i[0]) begin
      b = bclk_out;
      for (g = 0; g < 200 && bclk_out === b; g++) @(posedge pclk);
      b = bclk_out;
      for (n = 0; n < 200 && bclk_out === b; n++) @(posedge pclk);
      h = c[5] ? 3 : 6;
      if (div > h) h = div;
      chk_reg(n, h);
      f0 = frames;
      for (n = 0; n < 4000 && frames < f0 + 4; n++) @(posedge pclk);
      chk_reg({31'h0, frames >= f0 + 4}, 32'h1);
    end else begin
      codec_u.run(5);
      repeat (8) @(posedge pclk);
      apb(1'h0, `PVS_ADDR_STATUS, 32'h0);
      chk_reg({29'h0, rd[4:2]}, 32'h4);
    end
    chk_wd(m_rx, tx_exp(c, r[9:7], s));
    apb(1'h0, `PVS_ADDR_RXDATA, 32'h0);
    chk_wd(rd[15:0], rx_exp(c, m_tx));
    apb(1'h1, `PVS_ADDR_CTRL, 32'h0);
    $display("test %0d done", i);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `PVS_ADDR_CTRL, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'h0, `PVS_ADDR_CLKDIV, 32'h0);
    chk_reg(rd, {24'h0, `PVS_RST_CLKDIV});
    apb(1'h0, `PVS_ADDR_FRLEN, 32'h0);
    chk_reg(rd, {24'h0, `PVS_RST_FRLEN});
    apb(1'h0, 8'h1C, 32'h0);
    chk_reg({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++)
      frame_test(i);
    give_verdict();
  end
endmodule
bind pvs_port pvs_port_monitor mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .pcm_bclk_out(pcm_bclk_out), .pcm_bclk_oe_n(pcm_bclk_oe_n), .pcm_sync_out(pcm_sync_out),
  .pcm_sync_oe_n(pcm_sync_oe_n), .pcm_dout(pcm_dout), .pcm_dout_oe_n(pcm_dout_oe_n)
);
